// ### hw/lsc_pkg.sv
/*
  Constants, types and field layouts for the light sensor control block:
  register offsets, command codes, reset values, timing figures.
  Assumes it is compiled before any design file that refers to it.
*/
package lsc_pkg;
  // register offsets
  localparam logic [4:0] OFS_ENABLE = 5'h00;
  localparam logic [4:0] OFS_CONTROL = 5'h01;
  localparam logic [4:0] OFS_PLO_L = 5'h04;
  localparam logic [4:0] OFS_PLO_H = 5'h05;
  localparam logic [4:0] OFS_PHI_L = 5'h06;
  localparam logic [4:0] OFS_PHI_H = 5'h07;
  localparam logic [4:0] OFS_NLO_L = 5'h08;
  localparam logic [4:0] OFS_NLO_H = 5'h09;
  localparam logic [4:0] OFS_NHI_L = 5'h0a;
  localparam logic [4:0] OFS_NHI_H = 5'h0b;
  localparam logic [4:0] OFS_FILTER = 5'h0c;
  localparam logic [4:0] OFS_PKG = 5'h11;
  localparam logic [4:0] OFS_PART = 5'h12;
  localparam logic [4:0] OFS_FLAGS = 5'h13;
  localparam logic [4:0] OFS_C0_L = 5'h14;
  localparam logic [4:0] OFS_C0_H = 5'h15;
  localparam logic [4:0] OFS_C1_L = 5'h16;
  localparam logic [4:0] OFS_C1_H = 5'h17;
  // command byte fields
  localparam int CMD_BIT = 7;
  localparam logic [1:0] TRANS_NORMAL = 2'h1;
  localparam logic [1:0] TRANS_SPECIAL = 2'h3;
  localparam logic [4:0] SF_SET = 5'h04;
  localparam logic [4:0] SF_CLR_FILT = 5'h06;
  localparam logic [4:0] SF_CLR_BOTH = 5'h07;
  localparam logic [4:0] SF_CLR_IMM = 5'h0a;
  // enable, control and flag bit positions
  localparam int EN_IMM = 7;
  localparam int EN_SLEEP = 6;
  localparam int EN_FILT = 4;
  localparam int EN_CONV = 1;
  localparam int EN_OSC = 0;
  localparam int CTL_RESTART = 7;
  localparam int CTL_GAIN_LO = 4;
  localparam int FLG_IMM = 5;
  localparam int FLG_FILT = 4;
  localparam int FLG_VALID = 0;
  localparam int PKG_LO = 4;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // result saturation and timing
  localparam logic [15:0] MAX_SHORT = 16'h8fff;
  localparam logic [15:0] MAX_LONG = 16'hffff;
  localparam int STEP_MS = 100;
  localparam int LINK_KHZ = 83333;
  localparam logic [2:0] ITIME_LAST = 3'h5;
  localparam logic [5:0] FILTER_STEP = 6'h05;
  localparam logic [3:0] FILTER_LINEAR = 4'h3;
  localparam logic [6:0] BUS_ADDR = 7'h29;

  typedef struct packed {
    logic [15:0] ch1;
    logic [15:0] ch0;
  } lsc_result_t;

  typedef struct packed {
    logic immIrqEnable;
    logic sleepOnIrq;
    logic filteredIrqEnable;
    logic conversionEnable;
    logic oscillatorPower;
  } lsc_enable_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ADDR  = 3'h1,
    ST_ACK_A = 3'h2,
    ST_WR    = 3'h3,
    ST_ACK_W = 3'h4,
    ST_RD    = 3'h5,
    ST_ACK_R = 3'h6
  } lsc_state_t;

  typedef struct packed {
    lsc_enable_t en;
    logic [1:0]  ampGainSelect;
    logic [2:0]  integrationLength;
    logic [15:0] pLow;
    logic [15:0] pHigh;
    logic [15:0] iLow;
    logic [15:0] iHigh;
    logic [3:0]  filterCountField;
    logic        immIrqFlag;
    logic        filteredIrqFlag;
    logic        resultValidFlag;
    lsc_result_t result;
    logic [7:0]  shadow0;
    logic [7:0]  shadow1;
    logic [5:0]  outCount;
  } lsc_regs_t;
endpackage

// ### hw/lsc_top.sv
/*
  Control, threshold, interrupt and result logic of a two-channel light sensor,
  with a two-wire serial register port and an integration timer on the
  oscillator clock. Assumes the pins arrive unsynchronised, the analogue front
  end presents held counts on rawIn in the oscillator domain, and the pads
  resolve open-drain levels from the enables.
*/
`timescale 1ns/1ns
module lsc_top #(
  parameter int unsigned STEP_CYCLES = lsc_pkg::STEP_MS * lsc_pkg::LINK_KHZ,
  parameter logic [6:0]  DEV_ADDR    = lsc_pkg::BUS_ADDR,
  parameter logic [1:0]  PKG_CODE    = 2'h1,  // arbitrary value
  parameter logic [7:0]  PART_CODE   = 8'h3c  // arbitrary value
) (
  input  wire logic                 mclk,      // system clock
  input  wire logic                 rst,       // async reset, active high
  input  wire logic                 oscClk,    // oscillator clock
  input  wire logic                 sclIn,     // serial clock pin level
  input  wire logic                 sdaIn,     // serial data pin level
  output logic                      sdaOut,    // serial data drive value
  output logic                      sdaOeN,    // low while pulling data low
  output logic                      intOut,    // interrupt drive value
  output logic                      intOeN,    // low while interrupt asserted
  input  wire lsc_pkg::lsc_result_t rawIn,     // front-end counts, osc domain
  output logic [1:0]                ampGain,   // amplifier gain select
  output logic                      oscRun     // oscillator power request
);
  typedef struct packed {
    lsc_pkg::lsc_regs_t  regs;
    lsc_pkg::lsc_state_t st;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic [7:0] tx;
    logic [4:0] ptr;
    logic rnw;
    logic firstByte;
    logic nack;
    logic sclS1, sclS2, sclP;
    logic sdaS1, sdaS2, sdaP;
    logic tglS1, tglS2, tglP;
    logic runQ;
    logic sdaOeN;
    logic intOeN;
  } lsc_main_t;

  typedef struct packed {
    logic runS1, runS2;
    logic [2:0] itS1, itS2, itS3, itUse;
    logic [31:0] stepCnt;
    logic [2:0] stepNo;
    lsc_pkg::lsc_result_t res;
    logic tgl;
  } lsc_osc_t;

  lsc_main_t m_q, m_d;
  lsc_osc_t  o_q, o_d;

  // helper terms, also watched by the checks
  logic       resEvt, sclRise, sclFall, startC, stopC, sfPulse, wrPulse, rdLow0;
  logic [4:0] sfCode;
  logic [7:0] wrData, rdByte;
  logic       pOut, iOut, hit, filtSet, immSet, restart;
  logic [5:0] cntNext, target;

  // required consecutive count for a filter field value
  function automatic logic [5:0] filterTarget(input logic [3:0] f);
    if (f <= lsc_pkg::FILTER_LINEAR) begin
      filterTarget = {2'h0, f};
    end else begin
      filterTarget = 6'(lsc_pkg::FILTER_STEP * 6'({2'h0, f - lsc_pkg::FILTER_LINEAR}));
    end
  endfunction

  function automatic logic [15:0] sat16(input logic [15:0] v, input logic [15:0] lim);
    sat16 = (v > lim) ? lim : v;
  endfunction

  // register read map
  function automatic logic [7:0] readMap(input lsc_pkg::lsc_regs_t r, input logic [4:0] a);
    case (a)
      lsc_pkg::OFS_ENABLE:  readMap = {r.en.immIrqEnable, r.en.sleepOnIrq, 1'b0, r.en.filteredIrqEnable,
                                       2'h0, r.en.conversionEnable, r.en.oscillatorPower};
      lsc_pkg::OFS_CONTROL: readMap = {2'h0, r.ampGainSelect, 1'b0, r.integrationLength};
      lsc_pkg::OFS_PLO_L:   readMap = r.pLow[7:0];
      lsc_pkg::OFS_PLO_H:   readMap = r.pLow[15:8];
      lsc_pkg::OFS_PHI_L:   readMap = r.pHigh[7:0];
      lsc_pkg::OFS_PHI_H:   readMap = r.pHigh[15:8];
      lsc_pkg::OFS_NLO_L:   readMap = r.iLow[7:0];
      lsc_pkg::OFS_NLO_H:   readMap = r.iLow[15:8];
      lsc_pkg::OFS_NHI_L:   readMap = r.iHigh[7:0];
      lsc_pkg::OFS_NHI_H:   readMap = r.iHigh[15:8];
      lsc_pkg::OFS_FILTER:  readMap = {4'h0, r.filterCountField};
      lsc_pkg::OFS_PKG:     readMap = {2'h0, PKG_CODE, 4'h0};
      lsc_pkg::OFS_PART:    readMap = PART_CODE;
      lsc_pkg::OFS_FLAGS:   readMap = {2'h0, r.immIrqFlag, r.filteredIrqFlag, 3'h0, r.resultValidFlag};
      lsc_pkg::OFS_C0_L:    readMap = r.result.ch0[7:0];
      lsc_pkg::OFS_C0_H:    readMap = r.shadow0;
      lsc_pkg::OFS_C1_L:    readMap = r.result.ch1[7:0];
      lsc_pkg::OFS_C1_H:    readMap = r.shadow1;
      default:              readMap = lsc_pkg::RESET_BYTE;
    endcase
  endfunction

  // oscillator domain: step timer and result capture
  always_comb begin
    o_d = o_q;
    o_d.runS1 = m_q.runQ;
    o_d.runS2 = o_q.runS1;
    o_d.itS1 = m_q.regs.integrationLength;
    o_d.itS2 = o_q.itS1;
    o_d.itS3 = o_q.itS2;
    // a multi-bit word: take it only once two samples agree, never mid-change
    if (o_q.itS2 == o_q.itS3) begin
      o_d.itUse = o_q.itS3;
    end
    if (!o_q.runS2) begin
      o_d.stepCnt = 32'h0;
      o_d.stepNo = 3'h0;
    end else if (o_q.stepCnt == 32'(STEP_CYCLES - 1)) begin
      o_d.stepCnt = 32'h0;
      if (o_q.stepNo >= o_q.itUse || o_q.stepNo >= lsc_pkg::ITIME_LAST) begin
        // both channels captured together, next integration begins at once
        o_d.stepNo = 3'h0;
        o_d.res.ch0 = sat16(rawIn.ch0, (o_q.itUse == 3'h0) ? lsc_pkg::MAX_SHORT : lsc_pkg::MAX_LONG);
        o_d.res.ch1 = sat16(rawIn.ch1, (o_q.itUse == 3'h0) ? lsc_pkg::MAX_SHORT : lsc_pkg::MAX_LONG);
        o_d.tgl = ~o_q.tgl;
      end else begin
        o_d.stepNo = 3'(o_q.stepNo + 3'h1);
      end
    end else begin
      o_d.stepCnt = 32'(o_q.stepCnt + 32'h1);
    end
  end

  always_ff @(posedge oscClk or posedge rst) begin
    if (rst) begin
      o_q <= '0;
    end else begin
      o_q <= o_d;
    end
  end

  // system domain: serial port, registers and interrupt logic
  always_comb begin
    m_d = m_q;
    // pins pass two flops before anything reads them
    m_d.sclS1 = sclIn;
    m_d.sclS2 = m_q.sclS1;
    m_d.sclP = m_q.sclS2;
    m_d.sdaS1 = sdaIn;
    m_d.sdaS2 = m_q.sdaS1;
    m_d.sdaP = m_q.sdaS2;
    m_d.tglS1 = o_q.tgl;
    m_d.tglS2 = m_q.tglS1;
    m_d.tglP = m_q.tglS2;
    sclRise = m_q.sclS2 & ~m_q.sclP;
    sclFall = ~m_q.sclS2 & m_q.sclP;
    startC = m_q.sclS2 & m_q.sclP & m_q.sdaP & ~m_q.sdaS2;
    stopC = m_q.sclS2 & m_q.sclP & ~m_q.sdaP & m_q.sdaS2;
    sfPulse = 1'b0;
    sfCode = 5'h00;
    wrPulse = 1'b0;
    wrData = m_q.shift;
    rdLow0 = 1'b0;
    rdByte = readMap(m_q.regs, m_q.ptr);

    // bit engine
    if (sclRise) begin
      m_d.shift = {m_q.shift[6:0], m_q.sdaS2};
      m_d.bitCnt = 4'(m_q.bitCnt + 4'h1);
      if (m_q.st == lsc_pkg::ST_ACK_R) begin
        m_d.nack = m_q.sdaS2;
      end
    end
    if (startC) begin
      m_d.st = lsc_pkg::ST_ADDR;
      m_d.bitCnt = 4'h0;
      m_d.sdaOeN = 1'b1;
    end else if (stopC) begin
      m_d.st = lsc_pkg::ST_IDLE;
      m_d.sdaOeN = 1'b1;
    end else if (sclFall) begin
      case (m_q.st)
        lsc_pkg::ST_ADDR: begin
          if (m_q.bitCnt == 4'h8) begin
            if (m_q.shift[7:1] == DEV_ADDR) begin
              m_d.rnw = m_q.shift[0];
              m_d.firstByte = 1'b1;
              m_d.sdaOeN = 1'b0;
              m_d.st = lsc_pkg::ST_ACK_A;
            end else begin
              m_d.st = lsc_pkg::ST_IDLE;
            end
          end
        end
        lsc_pkg::ST_WR: begin
          if (m_q.bitCnt == 4'h8) begin
            if (m_q.firstByte) begin
              m_d.firstByte = 1'b0;
              if (m_q.shift[lsc_pkg::CMD_BIT] && m_q.shift[6:5] == lsc_pkg::TRANS_NORMAL) begin
                m_d.ptr = m_q.shift[4:0];
              end else if (m_q.shift[lsc_pkg::CMD_BIT] && m_q.shift[6:5] == lsc_pkg::TRANS_SPECIAL) begin
                sfPulse = 1'b1;
                sfCode = m_q.shift[4:0];
              end
            end else begin
              wrPulse = 1'b1;
              m_d.ptr = 5'(m_q.ptr + 5'h01);
            end
            m_d.sdaOeN = 1'b0;
            m_d.st = lsc_pkg::ST_ACK_W;
          end
        end
        lsc_pkg::ST_ACK_A, lsc_pkg::ST_ACK_W, lsc_pkg::ST_ACK_R: begin
          m_d.bitCnt = 4'h0;
          if (m_q.rnw && !(m_q.st == lsc_pkg::ST_ACK_R && m_q.nack)) begin
            // load next byte, latch the high byte on a low-byte read
            m_d.tx = rdByte;
            m_d.sdaOeN = rdByte[7];
            m_d.ptr = 5'(m_q.ptr + 5'h01);
            rdLow0 = (m_q.ptr == lsc_pkg::OFS_C0_L);
            if (m_q.ptr == lsc_pkg::OFS_C0_L) m_d.regs.shadow0 = m_q.regs.result.ch0[15:8];
            if (m_q.ptr == lsc_pkg::OFS_C1_L) m_d.regs.shadow1 = m_q.regs.result.ch1[15:8];
            m_d.st = lsc_pkg::ST_RD;
          end else if (m_q.rnw) begin
            m_d.sdaOeN = 1'b1;
            m_d.st = lsc_pkg::ST_IDLE;
          end else begin
            m_d.sdaOeN = 1'b1;
            m_d.st = lsc_pkg::ST_WR;
          end
        end
        lsc_pkg::ST_RD: begin
          if (m_q.bitCnt == 4'h8) begin
            m_d.sdaOeN = 1'b1;
            m_d.st = lsc_pkg::ST_ACK_R;
          end else begin
            m_d.tx = {m_q.tx[6:0], 1'b0};
            m_d.sdaOeN = m_q.tx[6];
          end
        end
        default: begin
          m_d.sdaOeN = 1'b1;
        end
      endcase
    end

    // end of an integration: compare, filter, raise flags
    resEvt = m_q.tglS2 ^ m_q.tglP;
    // compare the word being handed over, not the one it replaces
    pOut = (o_q.res.ch0 < m_q.regs.pLow) | (o_q.res.ch0 > m_q.regs.pHigh);
    iOut = (o_q.res.ch0 < m_q.regs.iLow) | (o_q.res.ch0 > m_q.regs.iHigh);
    cntNext = pOut ? ((m_q.regs.outCount == 6'h3f) ? m_q.regs.outCount : 6'(m_q.regs.outCount + 6'h01)) : 6'h00;
    target = filterTarget(m_q.regs.filterCountField);
    hit = (m_q.regs.filterCountField == 4'h0) | (pOut & (cntNext >= target));
    filtSet = resEvt & m_q.regs.en.filteredIrqEnable & hit;
    immSet = resEvt & m_q.regs.en.immIrqEnable & iOut;
    if (resEvt) begin
      // results are words held steady long after the toggle, safe to take here
      m_d.regs.result = o_q.res;
      m_d.regs.outCount = cntNext;
      m_d.regs.resultValidFlag = 1'b1;
      if (m_q.regs.en.sleepOnIrq && (filtSet || immSet)) begin
        m_d.regs.en.oscillatorPower = 1'b0;
      end
    end
    // flags: a set in the same cycle beats a clear
    m_d.regs.filteredIrqFlag = filtSet | (sfPulse & sfCode == lsc_pkg::SF_SET) |
      (m_q.regs.filteredIrqFlag & ~(sfPulse & (sfCode == lsc_pkg::SF_CLR_FILT | sfCode == lsc_pkg::SF_CLR_BOTH)));
    m_d.regs.immIrqFlag = immSet | (sfPulse & sfCode == lsc_pkg::SF_SET) |
      (m_q.regs.immIrqFlag & ~(sfPulse & (sfCode == lsc_pkg::SF_CLR_IMM | sfCode == lsc_pkg::SF_CLR_BOTH)));

    // register writes
    restart = 1'b0;
    if (wrPulse) begin
      case (m_q.ptr)
        lsc_pkg::OFS_ENABLE: begin
          m_d.regs.en = {wrData[lsc_pkg::EN_IMM], wrData[lsc_pkg::EN_SLEEP], wrData[lsc_pkg::EN_FILT],
                         wrData[lsc_pkg::EN_CONV], wrData[lsc_pkg::EN_OSC]};
          if (wrData[lsc_pkg::EN_CONV] && !m_q.regs.en.conversionEnable && !resEvt) begin  // set wins
            m_d.regs.resultValidFlag = 1'b0;
          end
        end
        lsc_pkg::OFS_CONTROL: begin
          restart = wrData[lsc_pkg::CTL_RESTART];
          m_d.regs.ampGainSelect = wrData[lsc_pkg::CTL_GAIN_LO +: 2];
          m_d.regs.integrationLength = wrData[2:0];
        end
        lsc_pkg::OFS_PLO_L: m_d.regs.pLow[7:0] = wrData;
        lsc_pkg::OFS_PLO_H: m_d.regs.pLow[15:8] = wrData;
        lsc_pkg::OFS_PHI_L: m_d.regs.pHigh[7:0] = wrData;
        lsc_pkg::OFS_PHI_H: m_d.regs.pHigh[15:8] = wrData;
        lsc_pkg::OFS_NLO_L: m_d.regs.iLow[7:0] = wrData;
        lsc_pkg::OFS_NLO_H: m_d.regs.iLow[15:8] = wrData;
        lsc_pkg::OFS_NHI_L: m_d.regs.iHigh[7:0] = wrData;
        lsc_pkg::OFS_NHI_H: m_d.regs.iHigh[15:8] = wrData;
        lsc_pkg::OFS_FILTER: m_d.regs.filterCountField = wrData[3:0];
        default: begin
          // read-only and unmapped offsets ignore writes
        end
      endcase
    end
    // restart returns every register to its power-up value; no bit keeps it
    if (restart) begin
      m_d.regs = '0;
    end
    m_d.runQ = m_d.regs.en.oscillatorPower & m_d.regs.en.conversionEnable;
    // pin shows flags only while an enable is on, held until cleared
    m_d.intOeN = ~((m_q.regs.immIrqFlag | m_q.regs.filteredIrqFlag) &
                   (m_q.regs.en.immIrqEnable | m_q.regs.en.filteredIrqEnable));
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      m_q <= '0;
      m_q.sdaOeN <= 1'b1;
      m_q.intOeN <= 1'b1;
      m_q.sclS1 <= 1'b1;
      m_q.sclS2 <= 1'b1;
      m_q.sclP <= 1'b1;
      m_q.sdaS1 <= 1'b1;
      m_q.sdaS2 <= 1'b1;
      m_q.sdaP <= 1'b1;
    end else begin
      m_q <= m_d;
    end
  end

  // outputs come straight from flops; drive values are held low
  assign sdaOut = m_q.regs.en.sleepOnIrq & 1'b0;
  assign intOut = m_q.regs.en.sleepOnIrq & 1'b0;
  assign sdaOeN = m_q.sdaOeN;
  assign intOeN = m_q.intOeN;
  assign ampGain = m_q.regs.ampGainSelect;
  assign oscRun = m_q.regs.en.oscillatorPower;

  // checks
  AST_SF_SET: assert property (@(posedge mclk) disable iff (rst)
    sfPulse && sfCode == lsc_pkg::SF_SET && !restart |=> m_q.regs.filteredIrqFlag && m_q.regs.immIrqFlag)
    else $error("set command did not raise both flags");
  AST_CLR_BOTH: assert property (@(posedge mclk) disable iff (rst)
    sfPulse && sfCode == lsc_pkg::SF_CLR_BOTH && !resEvt |=> !m_q.regs.filteredIrqFlag && !m_q.regs.immIrqFlag)
    else $error("clear command left a flag set");
  AST_PIN_GATE: assert property (@(posedge mclk) disable iff (rst)
    !intOeN |-> $past(m_q.regs.en.immIrqEnable || m_q.regs.en.filteredIrqEnable))
    else $error("interrupt pin driven with both enables off");
  AST_RESTART: assert property (@(posedge mclk) disable iff (rst)
    restart |=> m_q.regs == '0 ##1 !restart)
    else $error("restart did not clear the registers");
  AST_VALID: assert property (@(posedge mclk) disable iff (rst)
    resEvt && !restart |=> m_q.regs.resultValidFlag && m_q.regs.result == $past(o_q.res))
    else $error("cycle end did not post results");
  AST_SHADOW: assert property (@(posedge mclk) disable iff (rst)
    rdLow0 && !resEvt |=> m_q.regs.shadow0 == m_q.regs.result.ch0[15:8])
    else $error("low byte read did not latch high byte");
  AST_EVERY: assert property (@(posedge mclk) disable iff (rst)
    resEvt && !wrPulse && m_q.regs.en.filteredIrqEnable && m_q.regs.filterCountField == 4'h0 |=>
      m_q.regs.filteredIrqFlag ##1 !intOeN)
    else $error("filter zero did not interrupt every cycle");
  AST_IMMED: assert property (@(posedge mclk) disable iff (rst)
    resEvt && !restart && m_q.regs.en.immIrqEnable && iOut |=> m_q.regs.immIrqFlag)
    else $error("immediate threshold did not interrupt");
  AST_SLEEP: assert property (@(posedge mclk) disable iff (rst)
    resEvt && !wrPulse && m_q.regs.en.sleepOnIrq && (filtSet || immSet) |=> !oscRun)
    else $error("sleep after interrupt did not power down");
  AST_SAT: assert property (@(posedge oscClk) disable iff (rst)
    o_q.tgl != $past(o_q.tgl) && $past(o_q.itUse) == 3'h0 |-> o_q.res.ch0 <= lsc_pkg::MAX_SHORT)
    else $error("short integration result above saturation");
  AST_FLAG_HOLD: assert property (@(posedge mclk) disable iff (rst)
    m_q.regs.filteredIrqFlag && !sfPulse && !wrPulse |=> m_q.regs.filteredIrqFlag)
    else $error("filtered flag dropped without a clear");
  AST_IMM_HOLD: assert property (@(posedge mclk) disable iff (rst)
    m_q.regs.immIrqFlag && !sfPulse && !wrPulse |=> m_q.regs.immIrqFlag)
    else $error("immediate flag dropped without a clear");
  AST_GAIN: assert property (@(posedge mclk) disable iff (rst)
    wrPulse && m_q.ptr == lsc_pkg::OFS_CONTROL && !restart |=>
      ampGain == $past(wrData[lsc_pkg::CTL_GAIN_LO +: 2]))
    else $error("gain field not taken from control write");
endmodule // lsc_top

// ### tb/lsc_host.sv
/*
  Host bus master model driving the two-wire register port.
  Assumes the bench resolves the open-drain data line from both sides.
*/
`timescale 1ns/1ns
module lsc_host (
  input  wire logic mclk,   // paces the bus
  input  wire logic sdaBus, // resolved data line
  output logic      scl,    // clock drive
  output logic      sda     // data drive, 1 = released
);
  localparam logic [7:0] ADDR_W = {lsc_pkg::BUS_ADDR, 1'b0};
  logic ackOk; // every byte the host sent was acknowledged
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // third of a bit, 5 mclk, above the 4 mclk minimum
  task automatic hp();
    repeat (5) @(posedge mclk);
  endtask
  // data moves only while the clock is low
  task automatic bitX(input logic b, output logic r);
    sda <= b;
    hp();
    scl <= 1'b1;
    hp();
    r = sdaBus;
    scl <= 1'b0;
    hp();
  endtask
  task automatic start();
    sda <= 1'b1;
    hp();
    scl <= 1'b1;
    hp();
    sda <= 1'b0;
    hp();
    scl <= 1'b0;
    hp();
  endtask
  task automatic stop();
    sda <= 1'b0;
    hp();
    scl <= 1'b1;
    hp();
    sda <= 1'b1;
    hp();
  endtask
  task automatic put(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitX(b[i], r);
    bitX(1'b1, r);
    ackOk &= ~r;
  endtask
  // command byte, then n data bytes low first
  task automatic wr(input logic [7:0] cmd, input int n, input logic [31:0] d);
    ackOk = 1'b1;
    start();
    put(ADDR_W);
    put(cmd);
    for (int k = 0; k < n; k++)
      put(d[8*k+:8]);
    stop();
  endtask
  // whole sequence in one transfer, nack on the last byte
  task automatic rd(input logic [4:0] ofs, input int n, output logic [31:0] v);
    logic r;
    ackOk = 1'b1;
    v = '0;
    start();
    put(ADDR_W);
    put({1'b1, lsc_pkg::TRANS_NORMAL, ofs});
    start();
    put(ADDR_W | 8'h01);
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) begin
        bitX(1'b1, r);
        v[8*k+i] = r;
      end
      bitX(k == n - 1, r);
    end
    stop();
  endtask
endmodule // lsc_host

// ### tb/lsc_top_tb_top.sv
/*
  Self-checking bench for the light sensor control block.
  Assumes lsc_pkg, lsc_top and lsc_host are compiled first.
*/
`timescale 1ns/1ns
module lsc_top_tb_top;
  localparam int LIMIT = 90000;
  logic                 mclk = 1'b0;
  logic                 oscClk = 1'b0;
  logic                 rst = 1'b1;
  logic                 scl, sdaH, sdaOut, sdaOeN, intOut, intOeN, oscRun;
  logic [1:0]           ampGain;
  lsc_pkg::lsc_result_t rawIn = '0;
  logic [31:0]          v;
  int                   n_mismatch = 0;
  int                   comparisons = 0;
  int                   cyc = 0;
  wire                  sdaBus = sdaH & (sdaOeN | sdaOut); // pulled up
  // oscillator clock unrelated to mclk
  always #20 mclk = ~mclk;
  always #6 oscClk = ~oscClk;
  lsc_top #(.STEP_CYCLES(20)) uut (
    .mclk(mclk), .rst(rst), .oscClk(oscClk), .sclIn(scl), .sdaIn(sdaBus),
    .sdaOut(sdaOut), .sdaOeN(sdaOeN), .intOut(intOut), .intOeN(intOeN),
    .rawIn(rawIn), .ampGain(ampGain), .oscRun(oscRun));
  lsc_host host (.mclk(mclk), .sdaBus(sdaBus), .scl(scl), .sda(sdaH));
  function automatic logic [7:0] cmdN(input logic [4:0] o);
    return {1'b1, lsc_pkg::TRANS_NORMAL, o};
  endfunction
  function automatic logic [7:0] cmdS(input logic [4:0] o);
    return {1'b1, lsc_pkg::TRANS_SPECIAL, o};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_mismatch++;
      conclude();
    end
  end
  // unmapped 0x02, 0x03 read as zero too
  task automatic tReset();
    for (int o = 0; o <= 12; o++) begin
      host.rd(o[4:0], 1, v);
      chk("reset value", 32'h0, v);
    end
    host.rd(lsc_pkg::OFS_PKG, 2, v);
    chk("ident", 32'h3c10, v);
    chk("ack", 32'h1, host.ackOk);
  endtask
  task automatic tGain();
    for (int g = 0; g < 4; g++) begin
      host.wr(cmdN(lsc_pkg::OFS_CONTROL), 1, g << 4);
      chk("gain", g, ampGain);
    end
    host.wr(cmdN(lsc_pkg::OFS_PLO_L), 1, 32'h5a);
    host.wr(cmdN(lsc_pkg::OFS_CONTROL), 1, 32'h80);
    host.rd(lsc_pkg::OFS_CONTROL, 4, v);
    chk("restart", 32'h0, v);
    chk("gain reset", 32'h0, ampGain);
  endtask
  // conversion off: only commands move the flags
  task automatic tSf();
    host.wr(cmdS(lsc_pkg::SF_SET), 0, 0);
    host.rd(lsc_pkg::OFS_FLAGS, 1, v);
    chk("set", 32'h30, v);
    chk("pin masked", 32'h1, intOeN);
    host.wr(cmdN(lsc_pkg::OFS_ENABLE), 1, 32'h10);
    chk("pin on", 32'h0, intOeN);
    chk("int drive", 32'h0, intOut);
    host.wr(cmdS(lsc_pkg::SF_CLR_FILT), 0, 0);
    host.rd(lsc_pkg::OFS_FLAGS, 1, v);
    chk("clr filt", 32'h20, v);
    host.wr(cmdS(lsc_pkg::SF_CLR_BOTH), 0, 0);
    host.rd(lsc_pkg::OFS_FLAGS, 1, v);
    chk("clr both", 32'h0, v);
    chk("pin off", 32'h1, intOeN);
    host.wr(cmdS(lsc_pkg::SF_SET), 0, 0);
    host.wr(cmdS(lsc_pkg::SF_CLR_IMM), 0, 0);
    host.rd(lsc_pkg::OFS_FLAGS, 1, v);
    chk("clr imm", 32'h10, v);
    host.wr(cmdS(lsc_pkg::SF_CLR_BOTH), 0, 0);
  endtask
  task automatic tConv();
    @(posedge oscClk) rawIn <= 32'h1234ffff;
    host.wr(cmdN(lsc_pkg::OFS_ENABLE), 1, 32'h03);
    chk("osc", 32'h1, oscRun);
    host.rd(lsc_pkg::OFS_FLAGS, 1, v);
    chk("valid", 32'h1, v);
    host.rd(lsc_pkg::OFS_C0_L, 4, v);
    chk("short", {16'h1234, lsc_pkg::MAX_SHORT}, v);
    host.wr(cmdN(lsc_pkg::OFS_CONTROL), 1, 32'h01);
    host.rd(lsc_pkg::OFS_C0_L, 4, v);
    chk("long", 32'h1234ffff, v);
    host.rd(lsc_pkg::OFS_C0_L, 1, v);
    @(posedge oscClk) rawIn <= 32'h00000234;
    repeat (200) @(posedge oscClk);
    host.rd(lsc_pkg::OFS_C0_H, 1, v);
    chk("shadow", 32'hff, v);
    host.rd(lsc_pkg::OFS_C0_L, 4, v);
    chk("new", 32'h234, v);
    host.wr(cmdN(lsc_pkg::OFS_CONTROL), 1, 32'h00);
  endtask
  // ten consecutive out-of-range cycles of 20 oscillator clocks
  task automatic tPersist();
    int t;
    host.wr(cmdN(lsc_pkg::OFS_PLO_L), 4, 32'h08000100);
    @(posedge oscClk) rawIn <= 32'h00000400;
    // field still zero from restart: even in range every cycle interrupts
    host.wr(cmdN(lsc_pkg::OFS_ENABLE), 1, 32'h13);
    chk("every cycle", 32'h0, intOeN);
    host.wr(cmdN(lsc_pkg::OFS_FILTER), 1, 32'h05);
    host.wr(cmdS(lsc_pkg::SF_CLR_BOTH), 0, 0);
    repeat (300) @(posedge oscClk);
    chk("in range", 32'h1, intOeN);
    @(posedge oscClk) rawIn <= 32'h00000900;
    t = 0;
    while (intOeN === 1'b1 && t < 400) begin
      @(posedge oscClk);
      t++;
    end
    chk("filter time", 32'h1, (t >= 175) && (t <= 240));
    host.wr(cmdN(lsc_pkg::OFS_ENABLE), 1, 32'h00);
    host.wr(cmdS(lsc_pkg::SF_CLR_BOTH), 0, 0);
  endtask
  // filter count 10 still set: firing within the write shows it is bypassed
  task automatic tImm();
    host.wr(cmdN(lsc_pkg::OFS_NLO_L), 4, 32'hffff0200); // only the low limit can trip
    @(posedge oscClk) rawIn <= 32'h00000100;
    host.wr(cmdN(lsc_pkg::OFS_ENABLE), 1, 32'hc3);
    chk("imm pin", 32'h0, intOeN);
    chk("sleep", 32'h0, oscRun);
    host.rd(lsc_pkg::OFS_ENABLE, 1, v);
    chk("sleep en", 32'hc2, v);
    host.rd(lsc_pkg::OFS_FLAGS, 1, v);
    chk("imm flags", 32'h21, v);
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    tReset();
    tGain();
    tSf();
    tConv();
    tPersist();
    tImm();
    conclude();
  end
endmodule // lsc_top_tb_top
